// *** sadc_map.svh ***
// Register map, field positions, reset values and timing counts of the converter sequencer
// Assumes APB with 32-bit data; byte address is four times the register index
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define SADC_IDX_MODE 16'h0fd8
`define SADC_IDX_RESULT 16'h0fda
`define SADC_IDX_CLKCFG 16'h0fdc
`define SADC_ADDR_MODE 16'h3f60
`define SADC_ADDR_RESULT 16'h3f68
`define SADC_ADDR_CLKCFG 16'h3f70

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define SADC_MODE_CHAN_LSB 4
`define SADC_MODE_CHAN_MSB 6
`define SADC_MODE_START_BIT 3
`define SADC_MODE_EOC_BIT 2
`define SADC_MODE_BIAS_BIT 1
`define SADC_MODE_RESET 8'h04

// ----------------------------------------------------------------
// Clock configuration register fields
// ----------------------------------------------------------------
`define SADC_CFG_SYSCLK_LSB 0
`define SADC_CFG_SYSCLK_MSB 1
`define SADC_CFG_PROCCLK_LSB 2
`define SADC_CFG_PROCCLK_MSB 3
`define SADC_CFG_RESET 4'h0

// ----------------------------------------------------------------
// Timing, in main clock periods
// ----------------------------------------------------------------
`define SADC_START_PERIODS 16
`define SADC_CONV_PERIODS 168
`define SADC_SAMPLE_PERIODS 8
`define SADC_STEP_PERIODS ((`SADC_CONV_PERIODS - `SADC_SAMPLE_PERIODS) / 8)
`define SADC_PRESC_LAST 4'hf

`endif

// *** sadc_pkg.sv ***
// Types shared by the converter sequencer
// Assumes sadc_map.svh is on the include path
`include "sadc_map.svh"

package sadc_pkg;

    // Sequencer phases
    typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_STEP} sadc_phase_type;

    // Whole state of the sequencer
    typedef struct packed {
        sadc_phase_type phase;
        logic [4:0] cnt;
        logic [2:0] bitn;
        logic [7:0] code;
        logic [7:0] result;
        logic [2:0] chan;
        logic bias;
        logic start;
        logic eoc;
        logic [2:0] conv_chan;
        logic [3:0] clk_cfg;
        logic [3:0] presc;
        logic [1:0] sync;
    } sadc_state_type;

endpackage : sadc_pkg

// *** sadc_top.sv ***
// Successive-approximation converter sequencer with APB register access
// Assumes an analog front end with sample-and-hold, 8-bit DAC and comparator; one 125 MHz clock
//
// How it works
// - Eight-bit result from one of eight selectable analog inputs.
// - Hardware successive approximation, one result bit per step.
// - Selected input sampled once and held through the conversion.
// - Reset sets mode register to 04H, only end flag high.
// - End flag bit 2 and start bit 3 written only with the whole mode byte.
// - Mode bits 6 to 4 select the converted channel.
// - Mode bit 1 selects the comparator bias voltage.
// - Writing start bit begins conversion; hardware then clears it.
// - Finished conversion loads eight-bit outcome into result register.
// - End flag set to 1 when conversion completes.
// - Conversion begins and end flag clears within sixteen clocks.
// - One complete conversion takes 168 main clock periods.
// - Result register read only; writes have no effect.
// - Result register located at data address FDAH.
// - Result register cleared to 00H by reset.
// - Conversion halts while the main clock is not selected.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_map.svh"

module sadc_top
    import sadc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_in,
    output logic [7:0] analog_input_enable,
    output logic [2:0] channel_select,
    output logic comparator_bias_select,
    output logic sample_hold,
    output logic [7:0] dac_code,
    output logic converter_busy
);

    // ----------------------------------------------------------------
    // Decode and shared terms
    // ----------------------------------------------------------------
    sadc_state_type st_r;
    sadc_state_type st_nxt;
    logic acc;
    logic wr;
    logic hit_mode;
    logic hit_result;
    logic hit_cfg;
    logic halt;
    logic busy;
    logic comp_s;
    logic start_now;
    logic last_cnt;
    localparam logic [4:0] SAMPLE_LAST = 5'(`SADC_SAMPLE_PERIODS - 1);
    localparam logic [4:0] STEP_LAST = 5'(`SADC_STEP_PERIODS - 1);

    // Bus access terms; no wait states
    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign hit_mode = (paddr == `SADC_ADDR_MODE);
    assign hit_result = (paddr == `SADC_ADDR_RESULT);
    assign hit_cfg = (paddr == `SADC_ADDR_CLKCFG);
    assign pready = 1'b1;
    assign pslverr = acc && !(hit_mode || hit_result || hit_cfg);

    // Subsystem clock selected stops the converter
    assign halt = st_r.clk_cfg[`SADC_CFG_SYSCLK_MSB];
    assign busy = (st_r.phase != SADC_IDLE);
    assign comp_s = st_r.sync[1];
    // Start taken on prescaler wrap, at most sixteen clocks after request
    assign start_now = st_r.start && !halt && (st_r.presc == `SADC_PRESC_LAST);
    assign last_cnt = (st_r.phase == SADC_SAMPLE) ? (st_r.cnt == SAMPLE_LAST) : (st_r.cnt == STEP_LAST);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (hit_mode) begin
                prdata[`SADC_MODE_CHAN_MSB:`SADC_MODE_CHAN_LSB] = st_r.chan;
                prdata[`SADC_MODE_START_BIT] = st_r.start;
                prdata[`SADC_MODE_EOC_BIT] = st_r.eoc;
                prdata[`SADC_MODE_BIAS_BIT] = st_r.bias;
            end else if (hit_result) begin
                prdata[7:0] = st_r.result;
            end else if (hit_cfg) begin
                prdata[3:0] = st_r.clk_cfg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.presc = st_r.presc + 4'h1;
        st_nxt.sync = {st_r.sync[0], comparator_in};
        // Register writes, whole byte
        if (wr && hit_mode) begin
            st_nxt.chan = pwdata[`SADC_MODE_CHAN_MSB:`SADC_MODE_CHAN_LSB];
            st_nxt.bias = pwdata[`SADC_MODE_BIAS_BIT];
            st_nxt.eoc = pwdata[`SADC_MODE_EOC_BIT];
        end
        if (wr && hit_cfg) begin
            st_nxt.clk_cfg = pwdata[3:0];
        end
        // Result register ignores writes
        // Pending start consumed, or dropped while converter is stopped
        if (start_now || (st_r.start && halt)) begin
            st_nxt.start = 1'b0;
        end
        if (wr && hit_mode && pwdata[`SADC_MODE_START_BIT]) begin
            st_nxt.start = 1'b1;
        end
        if (start_now) begin
            // Begin or restart on the current channel
            st_nxt.phase = SADC_SAMPLE;
            st_nxt.cnt = 5'h00;
            st_nxt.conv_chan = st_r.chan;
            st_nxt.code = 8'h00;
            st_nxt.eoc = 1'b0;
        end else if (busy && !halt) begin
            st_nxt.cnt = last_cnt ? 5'h00 : st_r.cnt + 5'h01;
            unique case (st_r.phase)
                SADC_SAMPLE: begin
                    if (last_cnt) begin
                        st_nxt.phase = SADC_STEP;
                        st_nxt.bitn = 3'h7;
                        st_nxt.code = 8'h80;
                    end
                end
                SADC_STEP: begin
                    if (last_cnt) begin
                        // Keep trial bit when input at or above DAC level
                        st_nxt.code[st_r.bitn] = comp_s;
                        if (st_r.bitn == 3'h0) begin
                            st_nxt.phase = SADC_IDLE;
                            st_nxt.result = {st_r.code[7:1], comp_s};
                            st_nxt.eoc = 1'b1;
                        end else begin
                            st_nxt.bitn = st_r.bitn - 3'h1;
                            st_nxt.code[st_r.bitn - 3'h1] = 1'b1;
                        end
                    end
                end
                SADC_IDLE: begin
                    st_nxt.cnt = 5'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.phase <= SADC_IDLE;
            st_r.eoc <= 1'(`SADC_MODE_RESET >> `SADC_MODE_EOC_BIT);
            st_r.clk_cfg <= `SADC_CFG_RESET;
            st_r.result <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Analog front end controls
    // ----------------------------------------------------------------
    assign channel_select = st_r.conv_chan;
    assign comparator_bias_select = st_r.bias;
    assign sample_hold = (st_r.phase == SADC_SAMPLE);
    assign dac_code = st_r.code;
    assign converter_busy = busy;

    // One enable per analog input
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            assign analog_input_enable[gi] = busy && (st_r.conv_chan == 3'(gi));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [7:0] age_r;
    logic finish_now;
    logic start_wr;

    // Last approximation step completes at this edge; software start request
    assign finish_now = (st_r.phase == SADC_STEP) && last_cnt && (st_r.bitn == 3'h0) && !halt && !start_now;
    assign start_wr = wr && hit_mode && pwdata[`SADC_MODE_START_BIT];

    // Counts running cycles of the current conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 8'h00;
        end else if (!busy || start_now) begin
            age_r <= 8'h00;
        end else if (!halt) begin
            age_r <= age_r + 8'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_latency: assert property ($rose(st_r.start) |-> ##[1:16] (!st_r.start || halt))
        else $error("start bit not taken within sixteen clocks");

    a_eoc_cleared: assert property (start_now |=> (!st_r.eoc && st_r.phase == SADC_SAMPLE))
        else $error("end flag not cleared at conversion start");

    a_conv_length: assert property ($rose(st_r.eoc) && $past(busy) |-> $past(age_r) == 8'd167)
        else $error("conversion length not 168 clocks");

    a_result_load: assert property ($rose(st_r.eoc) && $past(busy) |->
        (st_r.result[0] == $past(comp_s) && st_r.result[7:1] == $past(st_r.code[7:1])))
        else $error("result does not match approximation");

    a_chan_hold: assert property (busy && $past(busy) && !$past(start_now) |-> $stable(channel_select))
        else $error("channel changed during conversion");

    a_sample_once: assert property ($fell(sample_hold) |-> st_r.phase == SADC_STEP && dac_code == 8'h80)
        else $error("sample phase not left cleanly");

    a_stop_start: assert property (halt && !busy |=> !busy)
        else $error("conversion started with subsystem clock");

    a_result_ro: assert property (wr && hit_result && !start_now && !busy |=> $stable(st_r.result))
        else $error("write changed result register");

    a_trial_bit: assert property (st_r.phase == SADC_STEP && st_r.cnt == 5'h00 |-> st_r.code[st_r.bitn])
        else $error("trial bit not set at step start");

    a_halt_freeze: assert property (busy && halt && !start_now |=> $stable(st_r.code) && $stable(st_r.cnt))
        else $error("conversion advanced while halted");

    // ----------------------------------------------------------------
    // Checks: start bit and end flag
    // ----------------------------------------------------------------
    a_start_clear: assert property (start_now && !start_wr |=> !st_r.start)
        else $error("start bit not cleared by hardware");

    a_eoc_set: assert property (finish_now |=> st_r.eoc && !busy)
        else $error("end flag not set at completion");

    a_eoc_hold: assert property (st_r.eoc && !busy && !(wr && hit_mode) && !start_now |=> st_r.eoc)
        else $error("end flag lost while idle");

    a_busy_eoc: assert property ($rose(busy) |-> !st_r.eoc)
        else $error("end flag still set at conversion start");

    a_start_dropped: assert property (st_r.start && halt && !(wr && hit_mode) |=> !st_r.start)
        else $error("pending start kept while stopped");

    // ----------------------------------------------------------------
    // Checks: analog side controls and read-back
    // ----------------------------------------------------------------
    a_enable_onehot: assert property (busy |-> analog_input_enable == (8'h01 << channel_select))
        else $error("input enable does not match channel");

    a_idle_quiet: assert property (!busy |-> analog_input_enable == 8'h00 && !sample_hold)
        else $error("analog controls active while idle");

    a_restart_chan: assert property (start_now |=> channel_select == $past(st_r.chan))
        else $error("conversion not on current channel");

    a_sample_dac: assert property (sample_hold |-> dac_code == 8'h00)
        else $error("trial code active during sampling");

    a_result_read: assert property (psel && !pwrite && hit_result |-> prdata == {24'h00_0000, st_r.result})
        else $error("result read-back wrong");

    a_unmapped_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    c_full_conv: cover property ($rose(st_r.eoc) && $past(busy));
    c_restart: cover property (busy && start_now);
    c_halted: cover property (busy && halt);
    c_start_dropped: cover property (st_r.start && halt);
    c_bus_error: cover property (pslverr);

endmodule : sadc_top

// *** sadc_analog.sv ***
// Analog side model: eight input levels, sample-and-hold, comparator
// Assumes the sequencer drives enable, sample_hold and dac_code from pclk
`timescale 1ns/100ps
module sadc_analog (
    input wire logic pclk,
    input wire logic [63:0] levels,
    input wire logic [7:0] analog_input_enable,
    input wire logic sample_hold,
    input wire logic [7:0] dac_code,
    output logic comparator_in
);
    logic [7:0] held = 8'h00;
    // Capture the enabled input only while sampling
    always @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            if (sample_hold && analog_input_enable[i]) begin
                held <= levels[i*8 +: 8];
            end
        end
    end
    // Comparator high when held level reaches the trial code
    assign comparator_in = (held >= dac_code);
endmodule : sadc_analog

// *** sar_adc_sequencer_test.sv ***
// Self-checking bench for the converter sequencer
// Assumes sadc_map.svh on the include path, APB with no wait states
`timescale 1ns/100ps
`include "sadc_map.svh"
module sar_adc_sequencer_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [63:0] levels = 64'h0;
    logic pready, pslverr, cmp, bsel, sh, busy, err, bz_d = 0, sh_d = 0, frz = 0;
    logic [7:0] aen, dac;
    logic [2:0] csel;
    int seed = 95, n_mismatch = 0, compares = 0, cyc = 0, bcnt = 0, n;

    always #4 pclk = ~pclk;

    sadc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_in(cmp), .analog_input_enable(aen), .channel_select(csel),
        .comparator_bias_select(bsel), .sample_hold(sh), .dac_code(dac), .converter_busy(busy));
    sadc_analog analog (.pclk(pclk), .levels(levels), .analog_input_enable(aen),
        .sample_hold(sh), .dac_code(dac), .comparator_in(cmp));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    // Start, watch sampling begin, poll end flag, read result
    task convert(input logic [2:0] ch, input logic b, input logic hlt);
        logic [7:0] e;
        e = levels[ch*8 +: 8];
        apb(1'b1, `SADC_ADDR_MODE, {24'h0, 1'b0, ch, 2'b10, b, 1'b0});
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (sh !== 1'b1 && n < 20);
        // n counts falling edges from the write edge: taken 1 to 16 edges later
        chk("start_delay", 1, n >= 2 && n <= 17);
        chk("input_enable", {24'h0, 8'h01 << ch}, aen);
        chk("chan_out", ch, csel);
        chk("bias_out", b, bsel);
        repeat (12) @(negedge pclk);
        levels[ch*8 +: 8] = ~e;
        // Optional stop in mid-conversion: nothing advances until released
        if (hlt) begin
            apb(1'b1, `SADC_ADDR_CLKCFG, 32'h0000_0002);
            frz = 1'b1;
            chk("frozen_busy", 1, busy);
            repeat (40) @(posedge pclk);
            apb(1'b0, `SADC_ADDR_MODE, 32'h0);
            chk("frozen_eoc", 0, rd[2]);
            chk("frozen_busy", 1, busy);
            apb(1'b1, `SADC_ADDR_CLKCFG, 32'h0);
            frz = 1'b0;
        end
        n = 0;
        do begin
            apb(1'b0, `SADC_ADDR_MODE, 32'h0);
            n++;
        end while (rd[2] !== 1'b1 && n < 100);
        chk("mode_done", {24'h0, 1'b0, ch, 2'b01, b, 1'b0}, rd);
        apb(1'b0, `SADC_ADDR_RESULT, 32'h0);
        chk("result", {24'h0, e}, rd);
    endtask : convert

    // Conversion length from sampling start to end of busy
    always @(negedge pclk) begin
        if (busy) bcnt = (sh && !sh_d) ? 1 : bcnt + !frz;
        else if (bz_d) chk("conv_len", 168, bcnt);
        if (busy && bcnt == 9) begin
            chk("hold_phase", 0, sh);
            chk("dac_first", 32'h0000_0080, dac);
        end
        bz_d = busy;
        sh_d = sh;
    end

    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            print_verdict;
        end
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SADC_ADDR_MODE, 32'h0);
        chk("mode_reset", 32'h0000_0004, rd);
        apb(1'b0, 16'h0000, 32'h0);
        chk("slverr", 1, err);
        chk("unmapped", 0, rd);
        for (int c = 0; c < 8; c++) begin
            levels[c*8 +: 8] = (c == 0) ? 8'h00 : (c == 7) ? 8'hff : 8'($random(seed));
            convert(c[2:0], c[0], 1'b0);
        end
        // Result register ignores writes
        apb(1'b1, `SADC_ADDR_RESULT, 32'h0000_005a);
        apb(1'b0, `SADC_ADDR_RESULT, 32'h0);
        // Last result came from channel 7 at full scale
        chk("result_ro", 32'h0000_00ff, rd);
        // Restart mid-conversion on another channel
        levels[47:40] = 8'($random(seed));
        apb(1'b1, `SADC_ADDR_MODE, 32'h0000_0028);
        repeat (60) @(posedge pclk);
        convert(3'd5, 1'b0, 1'b0);
        // Stop and resume in mid-conversion
        levels[15:8] = 8'($random(seed));
        convert(3'd1, 1'b1, 1'b1);
        // Subsystem clock selected: start has no effect
        apb(1'b1, `SADC_ADDR_CLKCFG, 32'h0000_0002);
        apb(1'b1, `SADC_ADDR_MODE, 32'h0000_0008);
        n = 0;
        repeat (40) begin
            @(negedge pclk);
            n += busy;
        end
        chk("halted", 0, n);
        apb(1'b1, `SADC_ADDR_CLKCFG, 32'h0);
        // Dropped start must not come back once running again
        repeat (20) @(negedge pclk);
        chk("start_dropped", 0, busy);
        print_verdict;
    end
endmodule : sar_adc_sequencer_test
